// ==== design/output_enable_margin_fault_ctrl.sv ====
// output enable, margining and fault response control of a step-down module
// Notes on behaviour
// - undervoltage fault: FETs off, latch/restart/ignore, not during rise
// - turn-on time fault: FETs off, response, alert, power-good low
// - warnings keep PWM, alert, power-good low
// - continuous conduction, low-side ramp over 128 cycles
// - pin-only mode, polarity fixed by the stored default, active high
// - command-only mode ignores control pin
// - combined mode needs pin and command
// - mode held until new command or pin change
// - loop follower refuses control commands, flags invalid command
// - on bit zero turns both drivers off
// - on needs input ok, gating, no fault
// - off bit zero: command turn-off immediate
// - off bit one: delay then ramp-down
// - read-only bits discard written values
// - on and off both set is invalid data
// - code 0001 nominal, under/overvoltage fault shutdown ignored, turn-on time fault still acts
// - codes 0000/0010/0011 nominal, faults act normally
// - 0101 margin-low ignore, 0110 margin-low act
// - 1001 margin-high ignore, 1010 margin-high act
// - other margin codes rejected as invalid data
// - margin targets from trim, step, loop scale
// - ignored faults still set status and alert
// - on bit used only when command response set
// - pin response bit requires pin asserted
// - power-up bit zero runs whenever powered
// - pin turn-off action chooses soft or immediate
`default_nettype none
module output_enable_margin_fault_ctrl #(
    parameter int RISE_CYCLES = 1000,
    parameter int TOFF_DELAY_CYCLES = 200,
    parameter int TOFF_FALL_CYCLES = 1000,
    parameter int VW = 16
) (
    // system clock and reset
    input  wire logic          sys_clk,
    input  wire logic          rst_n,
    // management link side, decoded command transactions
    input  wire logic          linkClk,
    input  wire logic          cmdValid,
    input  wire logic          cmdWrite,
    input  wire logic [7:0]    cmdCode,
    input  wire logic [7:0]    cmdData,
    output logic               cmdBusy,
    output logic               cmdDone,
    output logic               cmdNack,
    output logic [7:0]         cmdRdData,
    // asynchronous analog and pin inputs
    input  wire logic          controlPin,
    input  wire logic          vinAboveUvlo,
    input  wire logic          undervoltageFault,
    input  wire logic          overvoltageFault,
    input  wire logic          uvWarn,
    input  wire logic          ovWarn,
    input  wire logic          tonMaxFault,
    input  wire logic          loopFollower,
    input  wire logic          pwmTick,
    // fault responses and alert mask from other configuration
    input  wire logic [1:0]    uvFaultResp,
    input  wire logic [1:0]    ovFaultResp,
    input  wire logic [1:0]    tonMaxResp,
    input  wire logic [7:0]    alertMask,
    // reference inputs
    input  wire logic [VW-1:0] voutCommand,
    input  wire logic [VW-1:0] vrefTrim,
    input  wire logic [VW-1:0] stepMarginLow,
    input  wire logic [VW-1:0] stepMarginHigh,
    input  wire logic [VW-1:0] voutScaleLoop,
    // converter outputs
    output logic               switchEnable,
    output logic               highSideEn,
    output logic               lowSideEn,
    output logic               lowSideRampActive,
    output logic [6:0]         lowSideRampStep,
    output logic               softRampDown,
    output logic               softRampUp,
    output logic               power_good_output,
    output logic [1:0]         marginSel,
    output logic [VW-1:0]      vrefTarget,
    output logic [7:0]         statusBits,
    output logic               smbAlertOut,
    output logic               smbAlertOe
);
    localparam int RESTART_CYCLES = RISE_CYCLES * oemf_pkg::RESTART_RISES;
    localparam int NIN = 9;

    typedef enum logic [6:0] {
        ST_OFF     = 7'b0000001,
        ST_RISE    = 7'b0000010,
        ST_ON      = 7'b0000100,
        ST_TDLY    = 7'b0001000,
        ST_FALL    = 7'b0010000,
        ST_LATCH   = 7'b0100000,
        ST_RWAIT   = 7'b1000000
    } pwr_state_t;

    // ---------------- link domain ----------------
    logic       reqTgl_r;
    logic       ackMeta_r;
    logic       ackSync_r;
    logic       ackSeen_r;
    logic       lnkWr_r;
    logic [7:0] lnkCode_r;
    logic [7:0] lnkData_r;
    logic       ackTgl_r;
    logic       nackHold_r;
    logic [7:0] rdHold_r;

    // answer toggle synchroniser into the link clock
    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            ackMeta_r <= 1'b0;
            ackSync_r <= 1'b0;
        end else begin
            ackMeta_r <= ackTgl_r;
            ackSync_r <= ackMeta_r;
        end
    end

    // capture one command, hold it until the system side answers
    always_ff @(posedge linkClk or negedge rst_n) begin
        if (!rst_n) begin
            reqTgl_r  <= 1'b0;
            ackSeen_r <= 1'b0;
            cmdBusy   <= 1'b0;
            cmdDone   <= 1'b0;
            cmdNack   <= 1'b0;
            cmdRdData <= 8'h00;
            lnkWr_r   <= 1'b0;
            lnkCode_r <= 8'h00;
            lnkData_r <= 8'h00;
        end else begin
            cmdDone <= 1'b0;
            if (cmdBusy && ackSync_r != ackSeen_r) begin
                ackSeen_r <= ackSync_r;
                cmdBusy   <= 1'b0;
                cmdDone   <= 1'b1;
                cmdNack   <= nackHold_r;       // stable across the handshake
                cmdRdData <= rdHold_r;
            end else if (cmdValid && !cmdBusy) begin
                lnkWr_r   <= cmdWrite;
                lnkCode_r <= cmdCode;
                lnkData_r <= cmdData;
                reqTgl_r  <= ~reqTgl_r;
                cmdBusy   <= 1'b1;
            end
        end
    end

    // ---------------- system domain ----------------
    logic [NIN-1:0] inMeta_r;
    logic [NIN-1:0] inSync_r;
    logic           reqMeta_r;
    logic           reqSync_r;
    logic           reqSeen_r;

    // two-flop synchronisers for pins, analog flags and the request toggle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            inMeta_r  <= '0;
            inSync_r  <= '0;
            reqMeta_r <= 1'b0;
            reqSync_r <= 1'b0;
        end else begin
            inMeta_r  <= {pwmTick, loopFollower, tonMaxFault, ovWarn, uvWarn,
                          overvoltageFault, undervoltageFault, vinAboveUvlo, controlPin};
            inSync_r  <= inMeta_r;
            reqMeta_r <= reqTgl_r;
            reqSync_r <= reqMeta_r;
        end
    end

    logic pinRaw, vinOk, undervoltage_fault, ovF, uvW, ovW, tonF, follower, tick;
    assign {tick, follower, tonF, ovW, uvW, ovF, undervoltage_fault, vinOk, pinRaw} = inSync_r;

    logic       strapTaken_r;
    logic [1:0] strapDly_r;
    logic       follower_r;
    logic       polEff_r;
    logic [5:0] op_r;
    logic [4:0] cfg_r;
    logic [7:0] status_r;
    logic       tickDly_r;
    logic       pinDly_r;
    logic       cmdOffEvt_r;
    pwr_state_t state_r;
    pwr_state_t state_nxt;

    // follower strap is sampled once after reset release; polarity is taken from the
    // stored default then and never from later writes
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            strapTaken_r <= 1'b0;
            strapDly_r   <= 2'h0;
            follower_r   <= 1'b0;
            polEff_r     <= oemf_pkg::CFG_RESET[oemf_pkg::CFG_POL];
        end else if (!strapTaken_r) begin
            strapDly_r   <= {strapDly_r[0], 1'b1};
            strapTaken_r <= strapDly_r[1];
            follower_r   <= follower;
            polEff_r     <= cfg_r[oemf_pkg::CFG_POL];
        end
    end

    // command decode
    logic       reqNew;
    logic [3:0] wrMrg;
    logic       mrgBad;
    logic       ctrlCode;
    logic       knownCode;
    logic       opWrite;
    logic       opInvalid;
    assign reqNew    = reqSync_r != reqSeen_r;
    assign wrMrg     = lnkData_r[oemf_pkg::OP_MRG_HI:oemf_pkg::OP_MRG_LO];
    assign mrgBad    = wrMrg[3:2] == 2'b11 || wrMrg == 4'h4 || wrMrg == 4'h7
                     || wrMrg == 4'h8 || wrMrg == 4'hb;
    assign ctrlCode  = lnkCode_r == oemf_pkg::CMD_OPERATION || lnkCode_r == oemf_pkg::CMD_ON_OFF_CFG;
    assign knownCode = ctrlCode || (lnkCode_r == oemf_pkg::CMD_CLEAR_FAULTS && lnkWr_r);
    assign opWrite   = reqNew && lnkWr_r && lnkCode_r == oemf_pkg::CMD_OPERATION && !follower_r;
    assign opInvalid = (lnkData_r[oemf_pkg::OP_ON_BIT] && lnkData_r[oemf_pkg::OP_OFF_BIT])
                     || mrgBad;

    // registers written over the link, answer data returned by toggle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reqSeen_r  <= 1'b0;
            ackTgl_r   <= 1'b0;
            nackHold_r <= 1'b0;
            rdHold_r   <= 8'h00;
            op_r       <= oemf_pkg::OP_RESET;
            cfg_r      <= oemf_pkg::CFG_RESET;
        end else if (reqNew) begin
            reqSeen_r  <= reqSync_r;
            ackTgl_r   <= ~ackTgl_r;
            nackHold_r <= !knownCode || (ctrlCode && follower_r);
            rdHold_r   <= 8'h00;
            if (!lnkWr_r && !follower_r && lnkCode_r == oemf_pkg::CMD_OPERATION)
                rdHold_r <= {op_r, 2'b00};
            if (!lnkWr_r && !follower_r && lnkCode_r == oemf_pkg::CMD_ON_OFF_CFG)
                rdHold_r <= {3'b000, cfg_r};
            if (opWrite && !opInvalid)
                op_r <= lnkData_r[7:2];
            if (lnkWr_r && !follower_r && lnkCode_r == oemf_pkg::CMD_ON_OFF_CFG)
                cfg_r <= lnkData_r[4:0];
        end
    end

    // margin decode and fault gating
    logic [3:0] mrg;
    logic       faultIgnore;
    assign mrg = op_r[3:0];
    assign faultIgnore = mrg == oemf_pkg::MRG_OFF_IGN
                      || mrg == oemf_pkg::MRG_LOW_IGN || mrg == oemf_pkg::MRG_HIGH_IGN;

    // fault events that the state machine acts on
    logic inRise, running;
    logic uvAct, ovAct, tonAct;
    assign inRise  = state_r == ST_RISE;
    assign running = state_r == ST_ON || inRise;
    assign uvAct   = undervoltage_fault && state_r == ST_ON && !faultIgnore && uvFaultResp != oemf_pkg::RESP_IGNORE;
    assign ovAct   = ovF && running && !faultIgnore && ovFaultResp != oemf_pkg::RESP_IGNORE;
    assign tonAct  = tonF && inRise && tonMaxResp != oemf_pkg::RESP_IGNORE;

    // sticky status; a new event wins over a clear in the same cycle
    logic [7:0] stSet;
    logic       clrFaults;
    assign clrFaults = reqNew && lnkWr_r && lnkCode_r == oemf_pkg::CMD_CLEAR_FAULTS;
    always_comb begin
        stSet = 8'h00;
        stSet[oemf_pkg::ST_CML]    = opWrite && opInvalid;
        stSet[oemf_pkg::ST_IVD]    = opWrite && opInvalid;
        stSet[oemf_pkg::ST_IVC]    = reqNew && ctrlCode && follower_r;
        stSet[oemf_pkg::ST_UVF]    = undervoltage_fault && state_r == ST_ON;
        stSet[oemf_pkg::ST_OVF]    = ovF && running;
        stSet[oemf_pkg::ST_UVW]    = uvW && state_r == ST_ON;
        stSet[oemf_pkg::ST_OVW]    = ovW && running;
        stSet[oemf_pkg::ST_TONMAX] = tonF && inRise;
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            status_r <= 8'h00;
        else
            status_r <= (clrFaults ? 8'h00 : status_r) | stSet;
    end
    assign statusBits = status_r;

    // alert line, pulled low while any unmasked status bit stands
    assign smbAlertOut = 1'b0;
    assign smbAlertOe  = |(status_r & ~alertMask);

    // run request from pin, command and configuration
    logic pinActive, pinOk, cmdOk, runReq;
    assign pinActive = pinRaw == polEff_r;
    assign pinOk     = cfg_r[oemf_pkg::CFG_CPR] ? pinActive : 1'b1;
    assign cmdOk     = cfg_r[oemf_pkg::CFG_CMD] ? op_r[5] : 1'b1;
    assign runReq    = !cfg_r[oemf_pkg::CFG_PU] || (pinOk && cmdOk);

    // remembers whether the last stop request came from the command
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinDly_r    <= 1'b0;
            cmdOffEvt_r <= 1'b0;
        end else begin
            pinDly_r <= pinActive;
            if (pinDly_r != pinActive)
                cmdOffEvt_r <= 1'b0;
            else if (opWrite && !opInvalid)
                cmdOffEvt_r <= 1'b1;
        end
    end

    // soft stop choice: command uses off bit, pin uses pin action bit
    logic softStop;
    assign softStop = cmdOffEvt_r && cfg_r[oemf_pkg::CFG_CMD]
                    ? op_r[4]
                    : !cfg_r[oemf_pkg::CFG_CPA];

    // delay and ramp counter
    logic [31:0] cnt_r;
    logic        cntDone;
    logic        anyFault;
    logic [1:0]  faultResp;
    assign cntDone  = cnt_r == 32'h0;
    assign anyFault = uvAct || ovAct || tonAct;
    assign faultResp = tonAct ? tonMaxResp : (ovAct ? ovFaultResp : uvFaultResp);

    // power sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OFF:   if (runReq && vinOk && !strapFault()) state_nxt = ST_RISE;
            ST_RISE, ST_ON: begin
                if (!vinOk)
                    state_nxt = ST_OFF;
                else if (anyFault)
                    state_nxt = faultResp == oemf_pkg::RESP_RESTART ? ST_RWAIT : ST_LATCH;
                else if (!runReq)
                    state_nxt = softStop ? ST_TDLY : ST_OFF;
                else if (inRise && cntDone)
                    state_nxt = ST_ON;
            end
            ST_TDLY:  if (runReq) state_nxt = ST_RISE; else if (cntDone) state_nxt = ST_FALL;
            ST_FALL:  if (cntDone) state_nxt = ST_OFF;
            ST_LATCH: if (!runReq) state_nxt = ST_OFF;
            ST_RWAIT: if (cntDone) state_nxt = ST_OFF;
        endcase
        if (!vinOk && (state_r == ST_TDLY || state_r == ST_FALL)) state_nxt = ST_OFF;
    end

    function automatic logic strapFault();
        strapFault = !strapTaken_r;
    endfunction

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            state_r <= ST_OFF;
        else
            state_r <= state_nxt;
    end

    // counter loads on each state entry
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            cnt_r <= 32'h0;
        else if (state_nxt != state_r) begin
            unique case (state_nxt)
                ST_RISE:  cnt_r <= 32'(RISE_CYCLES - 1);
                ST_TDLY:  cnt_r <= 32'(TOFF_DELAY_CYCLES - 1);
                ST_FALL:  cnt_r <= 32'(TOFF_FALL_CYCLES - 1);
                ST_RWAIT: cnt_r <= 32'(RESTART_CYCLES - 1);
                default:  cnt_r <= 32'h0;
            endcase
        end else if (!cntDone)
            cnt_r <= cnt_r - 32'h1;
    end

    // low-side on-time ramp over the first switching cycles
    logic [7:0] rampCnt_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tickDly_r <= 1'b0;
            rampCnt_r <= 8'h00;
        end else begin
            tickDly_r <= tick;
            if (!switchEnable)
                rampCnt_r <= 8'h00;
            else if (tick && !tickDly_r && rampCnt_r != 8'(oemf_pkg::LS_RAMP_CYCLES))
                rampCnt_r <= rampCnt_r + 8'h01;
        end
    end

    // gate driver controls, held in flops
    logic swOn;
    assign swOn = state_nxt == ST_RISE || state_nxt == ST_ON || state_nxt == ST_TDLY
               || state_nxt == ST_FALL;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            switchEnable      <= 1'b0;
            highSideEn        <= 1'b0;
            lowSideEn         <= 1'b0;
            lowSideRampActive <= 1'b0;
            lowSideRampStep   <= 7'h00;
            softRampUp        <= 1'b0;
            softRampDown      <= 1'b0;
            power_good_output <= 1'b0;
        end else begin
            switchEnable      <= swOn;
            highSideEn        <= swOn;
            lowSideEn         <= swOn;
            lowSideRampActive <= swOn && rampCnt_r != 8'(oemf_pkg::LS_RAMP_CYCLES);
            lowSideRampStep   <= rampCnt_r[6:0];
            softRampUp        <= state_nxt == ST_RISE;
            softRampDown      <= state_nxt == ST_FALL;
            power_good_output <= state_nxt == ST_ON && !uvW && !ovW && !tonF;
        end
    end

    // reference selection and margin targets
    logic [VW-1:0] trimLow, trimHigh, divisor;
    assign divisor  = voutScaleLoop == '0 ? VW'(1) : voutScaleLoop;
    assign trimLow  = vrefTrim - stepMarginLow;
    assign trimHigh = vrefTrim + stepMarginHigh;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            marginSel  <= 2'h0;
            vrefTarget <= '0;
        end else if (mrg == oemf_pkg::MRG_LOW_IGN || mrg == oemf_pkg::MRG_LOW_ACT) begin
            marginSel  <= 2'h1;
            vrefTarget <= voutCommand + trimLow / divisor;
        end else if (mrg == oemf_pkg::MRG_HIGH_IGN || mrg == oemf_pkg::MRG_HIGH_ACT) begin
            marginSel  <= 2'h2;
            vrefTarget <= voutCommand + trimHigh / divisor;
        end else begin
            marginSel  <= 2'h0;
            vrefTarget <= voutCommand;
        end
    end
endmodule // output_enable_margin_fault_ctrl
`default_nettype wire

// ==== include/oemf_pkg.sv ====
// constants for the output enable, margin and fault control block
`default_nettype none
package oemf_pkg;
    // command codes on the management link
    localparam logic [7:0] CMD_OPERATION    = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CFG   = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    // control register field positions
    localparam int OP_ON_BIT   = 7;
    localparam int OP_OFF_BIT  = 6;
    localparam int OP_MRG_HI   = 5;
    localparam int OP_MRG_LO   = 2;
    localparam logic [5:0] OP_RESET = 6'h00;   // bits 7:2, bits 1:0 read zero
    // on/off configuration field positions and reset value
    localparam int CFG_PU  = 4;
    localparam int CFG_CMD = 3;
    localparam int CFG_CPR = 2;
    localparam int CFG_POL = 1;
    localparam int CFG_CPA = 0;
    localparam logic [4:0] CFG_RESET = 5'h16;
    // margin codes
    localparam logic [3:0] MRG_OFF_IGN  = 4'h1;
    localparam logic [3:0] MRG_LOW_IGN  = 4'h5;
    localparam logic [3:0] MRG_LOW_ACT  = 4'h6;
    localparam logic [3:0] MRG_HIGH_IGN = 4'h9;
    localparam logic [3:0] MRG_HIGH_ACT = 4'ha;
    // fault response codes
    localparam logic [1:0] RESP_LATCH   = 2'h0;
    localparam logic [1:0] RESP_RESTART = 2'h1;
    localparam logic [1:0] RESP_IGNORE  = 2'h2;
    // status bit positions
    localparam int ST_CML    = 0;
    localparam int ST_IVD    = 1;
    localparam int ST_IVC    = 2;
    localparam int ST_UVF    = 3;
    localparam int ST_OVF    = 4;
    localparam int ST_UVW    = 5;
    localparam int ST_OVW    = 6;
    localparam int ST_TONMAX = 7;
    // timing counts
    localparam int LS_RAMP_CYCLES  = 128;  // switching cycles of low-side ramp
    localparam int RESTART_RISES   = 7;    // rise times waited before restart
endpackage
`default_nettype wire

// ==== tb/link_host_model.sv ====
// host model that issues single-byte commands on the link
`default_nettype none
module link_host_model (
    // link clock and answer
    input wire logic       linkClk, cmdDone, cmdNack,
    input wire logic [7:0] cmdRdData,
    // request
    output logic           cmdValid, cmdWrite,
    output logic [7:0]     cmdCode, cmdData
);
    timeunit 1ns;
    timeprecision 100ps;
    initial {cmdValid, cmdWrite, cmdCode, cmdData} = 18'h0;
    // hold the request until answered, then release
    task automatic xfer(input logic w, input logic [7:0] c, d, output logic [9:0] ans);
        ans = 10'h0;
        @(posedge linkClk) #1;
        {cmdValid, cmdWrite, cmdCode, cmdData} = {1'h1, w, c, d};
        for (int i = 0; i < 40 && !ans[9]; i++) begin
            @(posedge linkClk) #1;
            ans = {cmdDone, cmdNack, cmdRdData};
        end
        {cmdValid, cmdCode, cmdData} = {1'h0, ~c, ~d};
    endtask
endmodule // link_host_model
`default_nettype wire

// ==== tb/oemf_ctrl_monitor.sv ====
// assertion checker on the control block ports
`default_nettype none
module oemf_monitor (
    // clocks and reset
    input wire logic       sys_clk, rst_n, linkClk,
    // watched ports
    input wire logic       cmdBusy, cmdDone, vinAboveUvlo, uvWarn, ovWarn, softRampUp, smbAlertOe,
    input wire logic       switchEnable, highSideEn, lowSideEn, lowSideRampActive, power_good_output,
    input wire logic [7:0] statusBits, alertMask
);
    timeunit 1ns;
    timeprecision 100ps;
    // a command is captured, then answered
    sequence cap_s;
        $rose(cmdBusy);
    endsequence
    sequence ans_s;
        ##[1:12] cmdDone;
    endsequence
    busy_ans_a: assert property (@(posedge linkClk) disable iff (!rst_n)
        cap_s |-> ans_s) else $error("command not answered");
    done_pulse_a: assert property (@(posedge linkClk) disable iff (!rst_n)
        cmdDone |=> !cmdDone) else $error("answer pulse too long");
    drv_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !switchEnable |-> !highSideEn && !lowSideEn) else $error("driver on while stopped");
    ramp_sw_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        lowSideRampActive |-> switchEnable) else $error("ramp while stopped");
    pg_sw_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        power_good_output |-> switchEnable && !softRampUp) else $error("power good outside on");
    warn_pg_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (uvWarn || ovWarn) [*4] |=> !power_good_output) else $error("power good in warning");
    alert_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        smbAlertOe == |(statusBits & ~alertMask)) else $error("alert not from status");
    uvlo_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !vinAboveUvlo [*4] |=> !switchEnable) else $error("switching with input low");
endmodule // oemf_monitor
bind output_enable_margin_fault_ctrl oemf_monitor u_mon (.*);
`default_nettype wire

// ==== tb/output_enable_margin_fault_ctrl_tb_top.sv ====
// self-checking bench for the output enable, margin and fault control block
`default_nettype none
module output_enable_margin_fault_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] OP = oemf_pkg::CMD_OPERATION, CF = oemf_pkg::CMD_ON_OFF_CFG;
    // inputs, all set at time zero
    logic sys_clk = 1'h0, linkClk = 1'h0, rst_n = 1'h0, controlPin = 1'h0, vinAboveUvlo = 1'h1;
    logic pwmTick = 1'h0, undervoltageFault = 1'h0, overvoltageFault = 1'h0, uvWarn = 1'h0;
    logic ovWarn = 1'h0, tonMaxFault = 1'h0, loopFollower = 1'h0;
    logic [1:0] uvFaultResp = 2'h0, ovFaultResp = 2'h0, tonMaxResp = 2'h0;
    logic [7:0] alertMask = 8'h00;
    logic [15:0] voutCommand = 16'h0064, vrefTrim = 16'h0014, stepMarginLow = 16'h0004;
    logic [15:0] stepMarginHigh = 16'h0006, voutScaleLoop = 16'h0002;
    // outputs
    logic cmdValid, cmdWrite, cmdBusy, cmdDone, cmdNack, switchEnable, highSideEn, lowSideEn;
    logic lowSideRampActive, softRampDown, softRampUp, power_good_output, smbAlertOut, smbAlertOe;
    logic [1:0] marginSel;
    logic [6:0] lowSideRampStep;
    logic [7:0] cmdCode, cmdData, cmdRdData, statusBits;
    logic [15:0] vrefTarget;
    int nMismatch = 0, checked = 0;
    // clocks and switching tick
    always #5 sys_clk = ~sys_clk;
    always #7.5 linkClk = ~linkClk;
    always #40 pwmTick = ~pwmTick;
    output_enable_margin_fault_ctrl #(.RISE_CYCLES(8), .TOFF_DELAY_CYCLES(4), .TOFF_FALL_CYCLES(8)) u_dut (.*);
    link_host_model u_host (.*);
    // compare and count
    task automatic chk(input logic [15:0] got, exp);
        #1 checked++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, nMismatch);
        if (nMismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one command, acked, read byte compared; no answer ends the run
    task automatic xc(input logic w, input logic [7:0] c, d, e);
        logic [9:0] a;
        u_host.xfer(w, c, d, a);
        chk(w ? {a[9:8], e} : a, {2'h2, e});
        if (a[9] !== 1'h1) finish_test();
    endtask
    // bounded wait for switching to reach a level
    task automatic wait_sw(input logic v, input int lim);
        for (int i = 0; i < lim && switchEnable !== v; i++) @(posedge sys_clk) #1;
        chk(switchEnable, v);
        if (switchEnable !== v) finish_test();
    endtask
    // reset values, pin-only start, ignored command, soft pin stop
    task automatic t_pin();
        xc(1'h0, OP, 8'h00, 8'h00);
        xc(1'h0, CF, 8'h00, 8'h16);
        @(posedge sys_clk) #1 controlPin = 1'h1;
        wait_sw(1'h1, 40);
        xc(1'h1, OP, 8'h00, 8'h00);
        repeat (20) @(posedge sys_clk);
        chk(switchEnable, 1'h1);
        @(posedge sys_clk) #1 controlPin = 1'h0;
        repeat (8) @(posedge sys_clk);
        chk(switchEnable, 1'h1);
        wait_sw(1'h0, 20);
    endtask
    // command-only and combined modes, immediate and soft command stops
    task automatic t_cmd();
        xc(1'h1, CF, 8'h1a, 8'h00);
        xc(1'h1, OP, 8'h80, 8'h00);
        wait_sw(1'h1, 40);
        xc(1'h1, OP, 8'h00, 8'h00);
        wait_sw(1'h0, 4);
        xc(1'h1, OP, 8'h80, 8'h00);
        wait_sw(1'h1, 40);
        xc(1'h1, OP, 8'h40, 8'h00);
        chk(switchEnable, 1'h1);
        wait_sw(1'h0, 40);
        xc(1'h1, CF, 8'h1e, 8'h00);
        xc(1'h1, OP, 8'h80, 8'h00);
        repeat (20) @(posedge sys_clk);
        chk(switchEnable, 1'h0);
        @(posedge sys_clk) #1 controlPin = 1'h1;
        wait_sw(1'h1, 40);
        xc(1'h1, CF, 8'h1a, 8'h00);
    endtask
    // every margin code: read-back, selection, target and invalid data flags
    task automatic t_margin();
        logic [7:0] op;
        logic ok;
        op = 8'h00;
        for (int c = 0; c < 16; c++) begin
            @(posedge sys_clk) #1 voutCommand = 16'h0064 + 16'(c);
            vrefTrim = 16'h0014 + 16'(2 * c);
            xc(1'h1, OP, {2'h0, 4'(c), 2'h3}, 8'h00);
            ok = c inside {0, 1, 2, 3, 5, 6, 9, 10};
            if (ok) op = {2'h0, 4'(c), 2'h0};
            xc(1'h0, OP, 8'h00, op);
            chk(statusBits[1:0], ok ? 2'h0 : 2'h3);
            chk(marginSel, op[5:4]);
            chk(vrefTarget, 16'h0064 + 16'(c) + (op[4] ? 16'(8 + c) : op[5] ? 16'(13 + c) : 16'h0));
            xc(1'h1, oemf_pkg::CMD_CLEAR_FAULTS, 8'h00, 8'h00);
        end
        xc(1'h1, OP, 8'hc0, 8'h00);
        xc(1'h0, OP, 8'h00, op);
        chk({statusBits[1:0], smbAlertOe}, 3'h7);
        xc(1'h1, oemf_pkg::CMD_CLEAR_FAULTS, 8'h00, 8'h00);
    endtask
    // ignored faults flag and alert, acted fault latches off, input loss stops
    task automatic t_fault();
        xc(1'h1, OP, 8'h84, 8'h00);
        wait_sw(1'h1, 40);
        @(posedge sys_clk) #1 {undervoltageFault, overvoltageFault, uvWarn, ovWarn, tonMaxFault} = 5'h1f;
        {ovFaultResp, tonMaxResp} = 4'ha;
        repeat (20) @(posedge sys_clk);
        chk({switchEnable, statusBits[4:3], smbAlertOe}, 4'hf);
        @(posedge sys_clk) #1 alertMask = 8'hf9;
        repeat (2) @(posedge sys_clk);
        chk(smbAlertOe, 1'h0);
        @(posedge sys_clk) #1 overvoltageFault = 1'h0;
        xc(1'h1, OP, 8'h80, 8'h00);
        wait_sw(1'h0, 20);
        @(posedge sys_clk) #1 undervoltageFault = 1'h0;
        repeat (20) @(posedge sys_clk);
        chk(switchEnable, 1'h0);
        xc(1'h1, OP, 8'h00, 8'h00);
        xc(1'h1, OP, 8'h80, 8'h00);
        wait_sw(1'h1, 40);
        @(posedge sys_clk) #1 vinAboveUvlo = 1'h0;
        wait_sw(1'h0, 6);
    endtask
    // reset as loop follower: control command refused
    task automatic t_follow();
        logic [9:0] a;
        @(posedge sys_clk) #1 {rst_n, loopFollower} = 2'h1;
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1'h1;
        repeat (4) @(posedge sys_clk);
        u_host.xfer(1'h0, OP, 8'h00, a);
        chk({a[9:8], statusBits[2], smbAlertOe}, 4'hf);
    endtask
    // reset, scenarios, verdict
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 rst_n = 1'h1;
        repeat (4) @(posedge sys_clk);
        t_pin();
        t_cmd();
        t_margin();
        t_fault();
        t_follow();
        finish_test();
    end
    // overall limit on the run
    initial begin
        #400000;
        nMismatch++;
        finish_test();
    end
endmodule // output_enable_margin_fault_ctrl_tb_top
`default_nettype wire
